// ### stc_timer_counter.sv
// Sixteen-bit timer/counter with AXI4-Lite registers
//
// The AXI4-Lite slave port and the address map were decided locally.
`default_nettype none

// Contract
// RQ1: Count only while run bit set
// RQ2: Wide bit selects 16-bit or byte access
// RQ3: Status bit shows system clock from oscillator
// RQ4: Prescale field divides by 1, 2, 4, 8
// RQ5: Oscillator enable bit powers the oscillator
// RQ6: Sync bypass bit only matters for external
// RQ7: Source bit picks external pin or Fosc/4
// RQ8: Timer, synchronous and asynchronous counter modes
// RQ9: Internal source counts every instruction cycle
// RQ10: External source counts rising pin edges
// RQ11: While running, pins are inputs reading 0
// RQ12: Wide mode: high address hits buffer
// RQ13: Wide mode: low read snapshots high byte
// RQ14: Wide mode: low write loads high from buffer
// RQ15: Low write clears prescaler; high does not
// RQ16: Oscillator keeps running in power modes
// RQ17: Software waits oscillator start-up before use
// RQ18: Wrap to zero sets overflow flag
// RQ19: Byte mode: high address is live byte
// RQ20: Async mode writes take effect safely
module stc_timer_counter (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [stc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic      [1:0]                    s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [stc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic      [31:0]                   s_axi_rdata,
    output logic      [1:0]                    s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          sysclk_from_lowpower_osc,
    output logic                               lowpower_osc_enable,
    input  wire logic                          osc_input_pin_in,
    output logic                               osc_input_pin_out,
    output logic                               osc_input_pin_oe,
    input  wire logic                          osc_output_pin_in,
    output logic                               osc_output_pin_out,
    output logic                               osc_output_pin_oe,
    input  wire logic [1:0]                    port_direction_bits,
    input  wire logic [1:0]                    port_latch,
    output logic      [1:0]                    port_read,
    output logic                               overflow_flag,
    output logic                               overflow_irq
);

    typedef struct packed {
        logic [7:0]                    ctrl;
        logic [15:0]                   count;
        logic [7:0]                    hbuf;
        logic                          ovf_flag;
        logic                          ovf_ie;
        logic [1:0]                    div;
        logic                          edge_pend;
        logic                          aw_got;
        logic [stc_pkg::AXI_ADDR_W-1:0] awaddr;
        logic                          w_got;
        logic [7:0]                    wdata;
        logic                          wstrb0;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          rvalid;
        logic [7:0]                    rdata;
        logic [1:0]                    rresp;
        logic [1:0]                    pin_oe;
        logic [1:0]                    pin_out;
        logic [1:0]                    port_rd;
    } stc_core_s;

    stc_core_s  s_q;
    stc_core_s  s_d;

    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic       instr_tick;
    logic       run;
    logic       ext_src;
    logic       sync_byp;
    logic       wide;
    logic       count_event;
    logic       pre_tick;
    logic       do_write;
    logic       wr_en;
    logic       wr_ctrl;
    logic       wr_low;
    logic       wr_high;
    logic       wr_stat;
    logic       wr_known;
    logic       rd_take;
    logic       rd_low;
    logic       ovf_event;

    // Both pins pass two flip-flops before any logic
    stc_pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_raw   ({osc_output_pin_in, osc_input_pin_in}),
        .pin_level (pin_level),
        .pin_rise  (pin_rise)
    );

    // Control fields
    assign run      = s_q.ctrl[stc_pkg::BIT_RUN];
    assign ext_src  = s_q.ctrl[stc_pkg::BIT_SOURCE];
    assign sync_byp = s_q.ctrl[stc_pkg::BIT_SYNC_BYP];
    assign wide     = s_q.ctrl[stc_pkg::BIT_WIDE];

    // Instruction-cycle enable, one pulse in four clocks
    assign instr_tick = (s_q.div == stc_pkg::INSTR_LAST);  // RQ9

    // Mode select: timer, synchronous counter, asynchronous counter
    always_comb begin
        if (!ext_src) begin
            count_event = instr_tick;  // RQ7 RQ8 RQ9
        end else if (sync_byp) begin
            count_event = pin_rise[stc_pkg::PIN_COUNT];  // RQ6 RQ10 RQ20
        end else begin
            count_event = s_q.edge_pend && instr_tick;  // RQ6 RQ10
        end
    end

    // Prescaler sees only events while running
    stc_prescaler #(
        .PRESCALE_W (3)
    ) u_prescaler (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clear     (wr_low),
        .event_in  (count_event && run),
        .ratio_sel (s_q.ctrl[stc_pkg::PS_LSB +: 2]),
        .tick_out  (pre_tick)
    );

    // Write and read decode
    assign do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    assign wr_en    = do_write && s_q.wstrb0;
    assign wr_ctrl  = wr_en && (s_q.awaddr == stc_pkg::ADDR_CONTROL);
    assign wr_low   = wr_en && (s_q.awaddr == stc_pkg::ADDR_COUNT_LOW);
    assign wr_high  = wr_en && (s_q.awaddr == stc_pkg::ADDR_COUNT_HI);
    assign wr_stat  = wr_en && (s_q.awaddr == stc_pkg::ADDR_STATUS);
    assign wr_known = (s_q.awaddr == stc_pkg::ADDR_CONTROL)
                   || (s_q.awaddr == stc_pkg::ADDR_COUNT_LOW)
                   || (s_q.awaddr == stc_pkg::ADDR_COUNT_HI)
                   || (s_q.awaddr == stc_pkg::ADDR_STATUS);
    assign rd_take  = s_axi_arvalid && s_axi_arready;
    assign rd_low   = rd_take && (s_axi_araddr == stc_pkg::ADDR_COUNT_LOW);

    assign ovf_event = pre_tick && run && !wr_low && !wr_high
                    && (s_q.count == stc_pkg::COUNT_MAX);

    // Next state of the whole block
    always_comb begin
        s_d = s_q;

        // Instruction-clock divider and synchronous edge capture
        s_d.div       = s_q.div + 2'h1;
        s_d.edge_pend = (s_q.edge_pend && !instr_tick) || pin_rise[stc_pkg::PIN_COUNT];

        // Status bit follows the system clock selector
        s_d.ctrl[stc_pkg::BIT_LP_STATUS] = sysclk_from_lowpower_osc;  // RQ3

        // Count up and wrap
        if (pre_tick && run) begin
            s_d.count = s_q.count + 16'h0001;  // RQ1 RQ18
        end

        // Sticky overflow flag, set wins over clear
        s_d.ovf_flag = (s_q.ovf_flag
                       && !(wr_stat && s_q.wdata[stc_pkg::ST_FLAG])) || ovf_event;  // RQ18

        // Register writes override the increment
        if (wr_ctrl) begin
            s_d.ctrl = (s_q.wdata & stc_pkg::CONTROL_WMASK)
                     | ({7'h00, sysclk_from_lowpower_osc} << stc_pkg::BIT_LP_STATUS);
        end
        if (wr_stat) begin
            s_d.ovf_ie = s_q.wdata[stc_pkg::ST_IE];
        end
        if (wr_low) begin
            s_d.count[7:0] = s_q.wdata;  // RQ20
            if (wide) begin
                s_d.count[15:8] = s_q.hbuf;  // RQ14
            end
        end
        if (wr_high) begin
            if (wide) begin
                s_d.hbuf = s_q.wdata;  // RQ12
            end else begin
                s_d.count[15:8] = s_q.wdata;  // RQ19
            end
        end

        // Write address and data, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got  = 1'b1;
            s_d.wdata  = s_axi_wdata[7:0];
            s_d.wstrb0 = s_axi_wstrb[0];
        end
        if (do_write) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = wr_known ? stc_pkg::RESP_OKAY : stc_pkg::RESP_SLVERR;
        end else if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Read answer, registered, with the low-byte snapshot
        if (rd_take) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = stc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                stc_pkg::ADDR_CONTROL: begin
                    s_d.rdata = s_q.ctrl;
                end
                stc_pkg::ADDR_COUNT_LOW: begin
                    s_d.rdata = s_q.count[7:0];
                    if (wide) begin
                        s_d.hbuf = s_q.count[15:8];  // RQ13
                    end
                end
                stc_pkg::ADDR_COUNT_HI: begin
                    s_d.rdata = wide ? s_q.hbuf : s_q.count[15:8];  // RQ2 RQ12 RQ19
                end
                stc_pkg::ADDR_STATUS: begin
                    s_d.rdata = {6'h00, s_q.ovf_ie, s_q.ovf_flag};
                end
                default: begin
                    s_d.rdata = 8'h00;
                    s_d.rresp = stc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // Pins forced to inputs reading 0 while running
        if (run) begin
            s_d.pin_oe  = 2'h0;  // RQ11
            s_d.port_rd = 2'h0;  // RQ11
        end else begin
            s_d.pin_oe  = ~port_direction_bits;
            s_d.port_rd = pin_level;
        end
        s_d.pin_out = port_latch;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Bus outputs
    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = {24'h000000, s_q.rdata};
    assign s_axi_rresp   = s_q.rresp;

    // Oscillator amplifier depends on its enable bit only, never on power mode
    assign lowpower_osc_enable = s_q.ctrl[stc_pkg::BIT_OSC_EN];  // RQ5 RQ16

    // Pin and flag outputs
    assign osc_input_pin_oe   = s_q.pin_oe[stc_pkg::PIN_OSC_IN];
    assign osc_input_pin_out  = s_q.pin_out[stc_pkg::PIN_OSC_IN];
    assign osc_output_pin_oe  = s_q.pin_oe[stc_pkg::PIN_COUNT];
    assign osc_output_pin_out = s_q.pin_out[stc_pkg::PIN_COUNT];
    assign port_read          = s_q.port_rd;
    assign overflow_flag      = s_q.ovf_flag;
    assign overflow_irq       = s_q.ovf_flag && s_q.ovf_ie;  // RQ18

    // Checks
    a_halt_when_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (!run && !wr_low && !wr_high) |=> (s_q.count == $past(s_q.count)))
        else $error("count moved while stopped"); // RQ1

    a_timer_step: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && !ext_src && s_q.ctrl[5:4] == stc_pkg::PS_DIV1 && instr_tick
         && !wr_low && !wr_high) |=> (s_q.count == $past(s_q.count) + 16'h0001))
        else $error("timer missed an instruction cycle"); // RQ9

    a_timer_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && !ext_src && !instr_tick && !wr_low && !wr_high)
        |=> (s_q.count == $past(s_q.count)))
        else $error("timer stepped off the instruction cycle"); // RQ7

    a_wide_snapshot: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_low && wide) |=> (s_q.hbuf == $past(s_q.count[15:8])))
        else $error("high buffer not loaded on low read"); // RQ13

    a_wide_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_low && wide) |=> (s_q.count == {$past(s_q.hbuf), $past(s_q.wdata)}))
        else $error("16-bit write not atomic"); // RQ14

    a_byte_high: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_high && !wide) |=> (s_q.count[15:8] == $past(s_q.wdata)))
        else $error("live high byte not written"); // RQ19

    a_pins_input: assert property (@(posedge aclk) disable iff (!aresetn)
        run ##1 run |-> (osc_input_pin_oe == 1'b0 && osc_output_pin_oe == 1'b0
                        && port_read == 2'h0))
        else $error("pins driven or read while running"); // RQ11

    a_overflow_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        ovf_event |=> (s_q.count == 16'h0000 && overflow_flag))
        else $error("overflow did not wrap and flag"); // RQ18

    a_status_track: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(sysclk_from_lowpower_osc) |=> s_q.ctrl[stc_pkg::BIT_LP_STATUS])
        else $error("clock status bit did not follow"); // RQ3

    a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        (ext_src && !sync_byp && !instr_tick) |-> !count_event)
        else $error("synchronous counter stepped off cycle"); // RQ6

endmodule : stc_timer_counter

`default_nettype wire

// ### stc_pkg.sv
// Shared constants of the sixteen-bit timer/counter
`default_nettype none

package stc_pkg;

    // Register map, byte addresses on the AXI4-Lite slave
    localparam int unsigned AXI_ADDR_W     = 4;
    localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
    localparam logic [3:0]  ADDR_COUNT_LOW = 4'h4;
    localparam logic [3:0]  ADDR_COUNT_HI  = 4'h8;
    localparam logic [3:0]  ADDR_STATUS    = 4'hc;

    // Control register fields
    localparam int unsigned BIT_RUN        = 0;
    localparam int unsigned BIT_SOURCE     = 1;
    localparam int unsigned BIT_SYNC_BYP   = 2;
    localparam int unsigned BIT_OSC_EN     = 3;
    localparam int unsigned PS_LSB         = 4;
    localparam int unsigned BIT_LP_STATUS  = 6;
    localparam int unsigned BIT_WIDE       = 7;
    localparam logic [7:0]  CONTROL_RESET  = 8'h00;
    localparam logic [7:0]  CONTROL_WMASK  = 8'hbf;

    // Status register fields
    localparam int unsigned ST_FLAG        = 0;
    localparam int unsigned ST_IE          = 1;

    // Prescale codes
    localparam logic [1:0]  PS_DIV1        = 2'h0;
    localparam logic [1:0]  PS_DIV2        = 2'h1;
    localparam logic [1:0]  PS_DIV4        = 2'h2;
    localparam logic [1:0]  PS_DIV8        = 2'h3;

    // Pin indices of the oscillator/count pair
    localparam int unsigned PIN_OSC_IN     = 0;
    localparam int unsigned PIN_COUNT      = 1;

    // Responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Instruction clock is the 40 MHz clock divided by four
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned INSTR_DIV      = 4;
    localparam logic [1:0]  INSTR_LAST     = 2'(INSTR_DIV - 1);
    localparam logic [15:0] COUNT_MAX      = 16'hffff;

endpackage : stc_pkg

`default_nettype wire

// ### stc_pin_sync.sv
// Two-stage pin synchroniser with rising-edge detect
`default_nettype none

module stc_pin_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] pin_raw,
    output logic      [WIDTH-1:0] pin_level,
    output logic      [WIDTH-1:0] pin_rise
);

    initial begin
        if (WIDTH < 1) $error("stc_pin_sync: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
    } stc_sync_s;

    stc_sync_s s_q;
    stc_sync_s s_d;

    // Shift chain; only the second stage reads the first
    always_comb begin
        s_d        = s_q;
        s_d.meta   = pin_raw;
        s_d.stable = s_q.meta;
        s_d.prev   = s_q.stable;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_level = s_q.stable;
    assign pin_rise  = s_q.stable & ~s_q.prev;

endmodule : stc_pin_sync

`default_nettype wire

// ### stc_prescaler.sv
// Input prescaler of the counter, 1:1 to 1:8
`default_nettype none

module stc_prescaler #(
    parameter int unsigned PRESCALE_W = 3
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       clear,
    input  wire logic       event_in,
    input  wire logic [1:0] ratio_sel,
    output logic            tick_out
);

    initial begin
        if (PRESCALE_W < 3) $error("stc_prescaler: PRESCALE_W below 3 cannot divide by 8");
    end

    typedef struct packed {
        logic [PRESCALE_W-1:0] count;
    } stc_pre_s;

    stc_pre_s              s_q;
    stc_pre_s              s_d;
    logic [PRESCALE_W-1:0] mask;

    // Ratio mask: all low bits set means the last event of a group
    always_comb begin
        case (ratio_sel)
            stc_pkg::PS_DIV2: mask = PRESCALE_W'(1);
            stc_pkg::PS_DIV4: mask = PRESCALE_W'(3);
            stc_pkg::PS_DIV8: mask = PRESCALE_W'(7);
            default:          mask = '0;
        endcase
    end

    assign tick_out = event_in && ((s_q.count & mask) == mask);  // RQ4

    // Count events; a low-byte write clears the count
    always_comb begin
        s_d = s_q;
        if (clear) begin
            s_d.count = '0;  // RQ15
        end else if (event_in) begin
            s_d.count = s_q.count + PRESCALE_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    a_clear_empties: assert property (@(posedge aclk) disable iff (!aresetn)
        clear |=> (s_q.count == '0)) else $error("prescaler not cleared"); // RQ15

    a_div8_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick_out && ratio_sel == stc_pkg::PS_DIV8 && !clear) |=> !tick_out [*1])
        else $error("prescaler ticked twice in a row at 1:8"); // RQ4

endmodule : stc_prescaler

`default_nettype wire

// ### stc_count_source.sv
// Model of the external count clock on the count pin
`default_nettype none

module stc_count_source (
    input  wire logic       aclk,
    input  wire logic       start,
    input  wire logic [7:0] pulses,
    output logic            busy,
    output logic            level
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] left_q = 8'h00;
    logic [2:0] ph_q = 3'h0;

    // Burst of rising edges, eight clocks apart, slow enough to sample
    always @(posedge aclk) begin
        if (start) begin
            left_q <= pulses;
            ph_q <= 3'h0;
        end else if (left_q != 8'h00) begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == 3'h7) begin
                left_q <= left_q - 8'h01;
            end
        end
    end

    // Line rests low between bursts
    assign busy  = (left_q != 8'h00);
    assign level = busy && ph_q[2];

endmodule : stc_count_source

`default_nettype wire

// ### test_sixteen_bit_timer_counter.sv
// Register-level testbench of the sixteen-bit timer/counter
`default_nettype none

module test_sixteen_bit_timer_counter;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [3:0] CT = stc_pkg::ADDR_CONTROL;
    localparam logic [3:0] LO = stc_pkg::ADDR_COUNT_LOW;
    localparam logic [3:0] HI = stc_pkg::ADDR_COUNT_HI;
    localparam logic [3:0] ST = stc_pkg::ADDR_STATUS;

    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, lp = 1'b0, start = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, osc_en, src_lvl, busy;
    logic [1:0]  bresp, rresp, port_read, dir = 2'b00, latch = 2'b10;
    logic        oi_out, oi_oe, oo_out, oo_oe, ovf, irq;
    logic [7:0]  pulses = 8'h00, d;
    logic [1:0]  r;
    logic [15:0] v, v2;
    int          failures = 0, cmp_count = 0;
    wire         oi_pin = oi_oe ? oi_out : 1'b1;
    wire         oo_pin = oo_oe ? oo_out : src_lvl;

    // Clock at 40 MHz
    always #12.5 aclk = ~aclk;

    stc_timer_counter dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sysclk_from_lowpower_osc(lp), .lowpower_osc_enable(osc_en),
        .osc_input_pin_in(oi_pin), .osc_input_pin_out(oi_out), .osc_input_pin_oe(oi_oe),
        .osc_output_pin_in(oo_pin), .osc_output_pin_out(oo_out),
        .osc_output_pin_oe(oo_oe), .port_direction_bits(dir), .port_latch(latch),
        .port_read(port_read), .overflow_flag(ovf), .overflow_irq(irq)
    );

    stc_count_source src (
        .aclk(aclk), .start(start), .pulses(pulses), .busy(busy), .level(src_lvl)
    );

    // Closing report and verdict
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Mid-cycle look at settled outputs, with a bound on every wait
    task automatic tick(inout int n);
        @(negedge aclk);
        n++;
        if (n > 300) begin
            failures++;
            finish_test();
        end
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [7:0] dat);
        int n;
        logic pa, pw, ra, rw, got;
        n = 0;
        pa = 1'b1;
        pw = 1'b1;
        got = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, dat};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw) begin
            tick(n);
            ra = awready;
            rw = wready;
            @(posedge aclk);
            if (pa && ra) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && rw) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        while (!got) begin
            tick(n);
            got = bvalid;
            @(posedge aclk);
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            tick(n);
            got = arready;
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        got = 1'b0;
        while (!got) begin
            tick(n);
            got = rvalid;
            d = rdata[7:0];
            r = rresp;
            @(posedge aclk);
        end
        rready <= 1'b0;
    endtask : rd

    task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] e);
        rd(a);
        chk(what, {24'h0, d}, {24'h0, e});
    endtask : rchk

    // Byte-mode read of the stopped count
    task automatic rdcnt(output logic [15:0] c);
        rd(LO);
        c[7:0] = d;
        rd(HI);
        c[15:8] = d;
    endtask : rdcnt

    task automatic pulse(input logic [7:0] k);
        int n;
        n = 0;
        @(posedge aclk);
        start <= 1'b1;
        pulses <= k;
        @(posedge aclk);
        start <= 1'b0;
        do tick(n); while (busy);
        repeat (6) @(posedge aclk);
    endtask : pulse

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("control reset", CT, stc_pkg::CONTROL_RESET);
        rchk("status reset", ST, 8'h00);
        rd(4'h2);
        chk("unmapped resp", {30'h0, r}, {30'h0, stc_pkg::RESP_SLVERR});
        chk("unmapped data", {24'h0, d}, 32'h0);
        wr(4'h2, 8'h00);
        chk("unmapped bresp", {30'h0, bresp}, {30'h0, stc_pkg::RESP_SLVERR});
        lp <= 1'b1;
        wr(CT, 8'h40);
        chk("write bresp", {30'h0, bresp}, {30'h0, stc_pkg::RESP_OKAY});
        rchk("clock status", CT, 8'h40);
        lp <= 1'b0;
        wr(CT, 8'h08);
        repeat (8) @(posedge aclk);
        chk("osc enable", {31'h0, osc_en}, 32'h1);
        chk("pins driven", {30'h0, oo_oe, oi_oe}, 32'h3);
        chk("pins read", {30'h0, port_read}, 32'h2);
        // Timer mode at every prescale ratio
        for (int c = 0; c < 4; c++) begin
            wr(LO, 8'h00);
            wr(HI, 8'h00);
            wr(CT, {2'b00, 2'(c), 4'b0001});
            repeat (256) @(posedge aclk);
            wr(CT, 8'h00);
            rdcnt(v);
            chk("timer count", 32'((v >= (16'd64 >> c) - 1) && (v <= (16'd64 >> c) + 2)), 1);
            repeat (40) @(posedge aclk);
            rdcnt(v2);
            chk("stopped count", {16'h0, v2}, {16'h0, v});
        end
        // Wrap to zero with the interrupt enabled
        wr(ST, 8'h02);
        wr(HI, 8'hff);
        wr(LO, 8'hf8);
        wr(CT, 8'h01);
        repeat (60) @(posedge aclk);
        chk("overflow flag", {31'h0, ovf}, 32'h1);
        chk("overflow irq", {31'h0, irq}, 32'h1);
        wr(CT, 8'h00);
        rdcnt(v);
        chk("wrapped count", 32'(v < 16'h0010), 32'h1);
        wr(ST, 8'h01);
        rchk("status cleared", ST, 8'h00);
        // Buffered high byte in wide mode
        wr(HI, 8'h55);
        wr(CT, 8'h80);
        wr(HI, 8'h12);
        wr(CT, 8'h00);
        rchk("live high", HI, 8'h55);
        wr(CT, 8'h80);
        wr(LO, 8'h34);
        wr(CT, 8'h00);
        rchk("loaded high", HI, 8'h12);
        rchk("loaded low", LO, 8'h34);
        wr(HI, 8'h77);
        wr(CT, 8'h80);
        rchk("low read", LO, 8'h34);
        rchk("snapshot", HI, 8'h77);
        // External edges, synchronised and bypassed
        for (int s = 0; s < 2; s++) begin
            wr(CT, 8'h00);
            wr(LO, 8'h00);
            wr(HI, 8'h00);
            wr(CT, {5'b0, 1'(s), 2'b11});
            // Pin enables settle one edge after the run bit lands
            @(negedge aclk);
            chk("osc off", {31'h0, osc_en}, 32'h0);
            chk("pins input", {30'h0, oo_oe, oi_oe}, 32'h0);
            chk("pins read zero", {30'h0, port_read}, 32'h0);
            pulse(8'h05);
            wr(CT, 8'h00);
            rdcnt(v);
            chk("edge count", {16'h0, v}, 32'h5);
        end
        // Prescaler cleared by low writes only; start from an empty prescaler
        wr(LO, 8'h00);
        wr(CT, 8'h33);
        pulse(8'h03);
        wr(LO, 8'h00);
        pulse(8'h05);
        rd(LO);
        chk("after low write", {24'h0, d}, 32'h0);
        // Five events kept; three more reach the eighth only if kept
        wr(HI, 8'h00);
        pulse(8'h03);
        rd(LO);
        chk("after high write", {24'h0, d}, 32'h1);
        finish_test();
    end

endmodule : test_sixteen_bit_timer_counter

`default_nettype wire
